// *** src/wtc_ctrl.sv ***
// wtc_ctrl: write-through cache controller with bus arbiter and timeout
// assumes external tag and data stores read within the addressed cycle
// What this block does
// - Cache lines are sixteen bytes and every fill or flush covers a line.
// - Each tag store entry is a twenty-bit word, one per line.
// - Depth is set between 4096 and 16384 lines with matching index width.
// - Each access but a byte-wide read compares the stored tag and a word read miss starts a line fill.
// - A write that hits a line flushes that line so memory and cache agree.
// - Every write goes on to memory whether it hits or not.
// - Writes leave through the external write buffer, not waiting for memory.
// - A reset from the host processor drives the bus reset.
// - The arbiter grants the bus and a master transfers only when granted.
// - A transfer left unacknowledged times out and ends in error.
// - Four byte reads from byte-wide devices are packed into one word.
// - Four error registers record bus faults for software.
// - A copy of the context register follows software writes.
// - A system enable register gates cache, arbitration and timeout.
`timescale 1ns/1ps
module wtc_ctrl
#(
   parameter int unsigned CACHE_LINES = wtc_pkg::MAX_LINES,
   parameter int unsigned NM = wtc_pkg::DEV_MASTERS,
   parameter int unsigned CTXW = wtc_pkg::CTX_W,
   parameter int unsigned TMO = wtc_pkg::TMO_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic hip_reset_i,
   input wire logic hip_req_i,
   input wire logic hip_we_i,
   input wire logic hip_bytewide_i,
   input wire logic [31:0] hip_addr_i,
   input wire logic [31:0] hip_wdata_i,
   output logic [31:0] hip_rdata_o,
   output logic hip_ack_o,
   output logic hip_err_o,
   output logic [$clog2(CACHE_LINES)-1:0] tag_addr_o,
   output logic tag_we_o,
   output wtc_pkg::wtc_tag_t tag_wdata_o,
   input wire wtc_pkg::wtc_tag_t tag_rdata_i,
   output logic [$clog2(CACHE_LINES)+1:0] cd_addr_o,
   output logic cd_we_o,
   output logic [31:0] cd_wdata_o,
   input wire logic [31:0] cd_rdata_i,
   output logic wbuf_valid_o,
   input wire logic wbuf_ready_i,
   output logic [31:0] wbuf_addr_o,
   output logic [31:0] wbuf_data_o,
   output logic sb_reset_o,
   input wire logic [NM-1:0] sb_br_i,
   output logic [NM-1:0] sb_bg_o,
   input wire logic sb_dev_as_i,
   output wtc_pkg::wtc_sbm_t sbm_o,
   input wire logic [31:0] sb_data_i,
   input wire logic sb_ack_i,
   input wire logic sb_err_i,
   input wire logic sb_rerun_i,
   output logic sb_tmo_o,
   output logic [CTXW-1:0] ctx_o
);
   import wtc_pkg::*;
   localparam int unsigned IDXW = $clog2(CACHE_LINES);

   function automatic logic [IDXW-1:0] idx_of(input logic [31:0] a);
      idx_of = a[OFFS_W +: IDXW];
   endfunction
   function automatic logic [TAG_W-2:0] tag_of(input logic [31:0] a);
      tag_of = (TAG_W-1)'(a >> (OFFS_W + IDXW));
   endfunction
   function automatic logic [NM:0] first_one(input logic [NM:0] v);
      first_one = v & (~v + 1'b1);
   endfunction

   wtc_state_t st_reg, st_next;
   wtc_kind_t kind_reg, kind_next;
   logic [IDXW-1:0] idx_reg, idx_next;
   logic [1:0] cdw_reg, cdw_next, beat_reg, beat_next;
   logic [31:0] addr_reg, addr_next, wdat_reg, wdat_next;
   logic [31:0] baddr_reg, baddr_next, rdata_reg, rdata_next;
   logic [31:0] cdwd_reg, cdwd_next;
   logic we_reg, we_next, byte_reg, byte_next;
   logic ack_reg, ack_next, err_reg, err_next;
   logic tag_we_reg, tag_we_next, cd_we_reg, cd_we_next;
   wtc_tag_t tagwd_reg, tagwd_next;
   logic hit, match, own_req, own_tmo, tmo_hit, fault;

   logic [CTXW-1:0] ctx_reg, ctx_next;
   logic [2:0] sysen_reg, sysen_next, cause_reg, cause_next;
   logic [31:0] eaddr_reg, eaddr_next, dat_reg, dat_next;
   logic [NM:0] emast_reg, emast_next, gnt_reg, gnt_next;
   logic [7:0] ecnt_reg, ecnt_next;
   logic [15:0] tmo_reg, tmo_next;
   logic wack_reg, wack_next, sbrst_reg;

   // writes flush on match even with the cache off, so no stale line survives
   assign match = tag_rdata_i.valid
      && tag_rdata_i.tag == tag_of(addr_reg);
   assign hit = sysen_reg[SYSEN_CACHE] && match;
   assign own_req = st_reg == S_BREQ || st_reg == S_XFER;
   assign own_tmo = tmo_hit && st_reg == S_XFER;
   assign fault = st_reg == S_XFER && !sb_ack_i && (sb_err_i || own_tmo);

   assign tag_addr_o = idx_reg;
   assign tag_we_o = tag_we_reg;
   assign tag_wdata_o = tagwd_reg;
   assign cd_addr_o = {idx_reg, cdw_reg};
   assign cd_we_o = cd_we_reg;
   assign cd_wdata_o = cdwd_reg;
   assign hip_rdata_o = rdata_reg;
   assign hip_ack_o = ack_reg;
   assign hip_err_o = err_reg;
   assign wbuf_valid_o = st_reg == S_WPUSH;
   assign wbuf_addr_o = addr_reg;
   assign wbuf_data_o = wdat_reg;
   assign sbm_o = '{as: st_reg == S_XFER, byte_sz: kind_reg == K_BYTE,
                    addr: baddr_reg};
   assign sb_bg_o = gnt_reg[NM:1];
   assign sb_reset_o = sbrst_reg;
   assign sb_tmo_o = tmo_hit && sb_dev_as_i && st_reg != S_XFER;
   assign ctx_o = ctx_reg;
   assign wb_dat_o = dat_reg;
   assign wb_ack_o = wack_reg;

   always_comb
   begin
      st_next = st_reg;
      kind_next = kind_reg;
      idx_next = idx_reg;
      cdw_next = cdw_reg;
      beat_next = beat_reg;
      addr_next = addr_reg;
      wdat_next = wdat_reg;
      baddr_next = baddr_reg;
      rdata_next = rdata_reg;
      cdwd_next = cdwd_reg;
      we_next = we_reg;
      byte_next = byte_reg;
      tagwd_next = tagwd_reg;
      ack_next = 1'b0;
      err_next = 1'b0;
      tag_we_next = 1'b0;
      cd_we_next = 1'b0;
      case (st_reg)
         S_INIT:
         begin
            // external tags hold garbage at power-up: sweep them invalid
            tag_we_next = 1'b1;
            tagwd_next = '0;
            if (tag_we_reg)
            begin
               if (idx_reg == IDXW'(CACHE_LINES - 1))
               begin
                  tag_we_next = 1'b0;
                  st_next = S_IDLE;
               end
               else
                  idx_next = idx_reg + 1'b1;
            end
         end
         S_IDLE:
         begin
            // hold off while the last answer is still on the port
            if (hip_req_i && !ack_reg && !err_reg)
            begin
               addr_next = hip_addr_i;
               wdat_next = hip_wdata_i;
               we_next = hip_we_i;
               byte_next = hip_bytewide_i;
               idx_next = idx_of(hip_addr_i);
               cdw_next = hip_addr_i[3:2];
               st_next = S_LOOK;
            end
         end
         S_LOOK:
         begin
            beat_next = 2'd0;
            if (we_reg)
            begin
               if (match)
               begin
                  tag_we_next = 1'b1;
                  tagwd_next = '0;
               end
               st_next = S_WPUSH;
            end
            else if (byte_reg)
            begin
               kind_next = K_BYTE;
               baddr_next = addr_reg;
               st_next = S_BREQ;
            end
            else if (hit)
            begin
               rdata_next = cd_rdata_i;
               ack_next = 1'b1;
               st_next = S_IDLE;
            end
            else if (sysen_reg[SYSEN_CACHE])
            begin
               kind_next = K_FILL;
               baddr_next = {addr_reg[31:OFFS_W], 4'h0};
               // drop the old tag first: a fill cut by an error leaves
               // part of the line rewritten
               tag_we_next = 1'b1;
               tagwd_next = '0;
               st_next = S_BREQ;
            end
            else
            begin
               kind_next = K_SINGLE;
               baddr_next = {addr_reg[31:2], 2'b00};
               st_next = S_BREQ;
            end
         end
         S_WPUSH:
         begin
            if (wbuf_ready_i)
            begin
               ack_next = 1'b1;
               st_next = S_IDLE;
            end
         end
         S_BREQ:
         begin
            if (gnt_reg[0])
               st_next = S_XFER;
         end
         S_XFER:
         begin
            if (sb_ack_i)
            begin
               case (kind_reg)
                  K_FILL:
                  begin
                     cd_we_next = 1'b1;
                     cdw_next = beat_reg;
                     cdwd_next = sb_data_i;
                     if (beat_reg == addr_reg[3:2])
                        rdata_next = sb_data_i;
                     if (beat_reg == 2'd3)
                     begin
                        tag_we_next = 1'b1;
                        tagwd_next = '{valid: 1'b1, tag: tag_of(addr_reg)};
                        ack_next = 1'b1;
                        st_next = S_IDLE;
                     end
                  end
                  K_BYTE:
                  begin
                     rdata_next = {rdata_reg[23:0], sb_data_i[7:0]};
                     if (beat_reg == 2'd3)
                     begin
                        ack_next = 1'b1;
                        st_next = S_IDLE;
                     end
                  end
                  default:
                  begin
                     rdata_next = sb_data_i;
                     ack_next = 1'b1;
                     st_next = S_IDLE;
                  end
               endcase
               beat_next = beat_reg + 2'd1;
               baddr_next = baddr_reg + (kind_reg == K_BYTE ? 32'h1 : 32'h4);
            end
            else if (fault)
            begin
               err_next = 1'b1;
               st_next = S_IDLE;
            end
            else if (sb_rerun_i)
               st_next = S_RERUN;
         end
         // drop the request one cycle so the arbiter may regrant
         S_RERUN: st_next = S_BREQ;
         default: st_next = S_INIT;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg <= S_INIT;
         kind_reg <= K_FILL;
         idx_reg <= '0;
         cdw_reg <= 2'd0;
         beat_reg <= 2'd0;
         addr_reg <= '0;
         wdat_reg <= '0;
         baddr_reg <= '0;
         rdata_reg <= '0;
         cdwd_reg <= '0;
         we_reg <= 1'b0;
         byte_reg <= 1'b0;
         tagwd_reg <= '0;
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         tag_we_reg <= 1'b0;
         cd_we_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         kind_reg <= kind_next;
         idx_reg <= idx_next;
         cdw_reg <= cdw_next;
         beat_reg <= beat_next;
         addr_reg <= addr_next;
         wdat_reg <= wdat_next;
         baddr_reg <= baddr_next;
         rdata_reg <= rdata_next;
         cdwd_reg <= cdwd_next;
         we_reg <= we_next;
         byte_reg <= byte_next;
         tagwd_reg <= tagwd_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
         tag_we_reg <= tag_we_next;
         cd_we_reg <= cd_we_next;
      end
   end

   assign tmo_hit = sysen_reg[SYSEN_TMO] && (sbm_o.as || sb_dev_as_i)
      && !(sb_ack_i || sb_err_i || sb_rerun_i) && tmo_reg == 16'(TMO - 1);

   always_comb
   begin
      logic acc;
      logic wr;
      logic [NM:0] reqs;
      acc = wb_cyc_i && wb_stb_i && !wack_reg;
      wr = acc && wb_we_i && wb_sel_i[0];
      reqs = {sb_br_i & {NM{sysen_reg[SYSEN_ARB]}}, own_req};
      ctx_next = ctx_reg;
      sysen_next = sysen_reg;
      cause_next = cause_reg;
      eaddr_next = eaddr_reg;
      emast_next = emast_reg;
      ecnt_next = ecnt_reg;
      wack_next = acc;
      dat_next = '0;
      if (acc && !wb_we_i)
      begin
         case (wb_adr_i)
            REG_CTX: dat_next = 32'(ctx_reg);
            REG_SYSEN: dat_next = 32'(sysen_reg);
            REG_STATUS: dat_next = {29'h0, st_reg != S_IDLE, gnt_reg[0],
                                    st_reg == S_INIT};
            REG_ERR_CAUSE: dat_next = 32'(cause_reg);
            REG_ERR_ADDR: dat_next = eaddr_reg;
            REG_ERR_MASTER: dat_next = 32'(emast_reg);
            REG_ERR_COUNT: dat_next = 32'(ecnt_reg);
            default: dat_next = '0;
         endcase
      end
      if (wr && wb_adr_i == REG_CTX)
         ctx_next = wb_dat_i[CTXW-1:0];
      if (wr && wb_adr_i == REG_SYSEN)
         sysen_next = wb_dat_i[2:0];
      if (wr && wb_adr_i == REG_ERR_CAUSE)
         cause_next = cause_reg & ~wb_dat_i[2:0];
      if (wr && wb_adr_i == REG_ERR_COUNT)
         ecnt_next = '0;
      // fault capture after the clears, so a new fault is never lost
      if (fault)
      begin
         cause_next[CAUSE_TMO] = cause_next[CAUSE_TMO] | own_tmo;
         cause_next[CAUSE_ERR] = cause_next[CAUSE_ERR] | sb_err_i;
         eaddr_next = baddr_reg;
         emast_next = gnt_reg;
      end
      if (sb_tmo_o)
      begin
         cause_next[CAUSE_DEV] = 1'b1;
         emast_next = gnt_reg;
      end
      if ((fault || sb_tmo_o) && ecnt_next != ERR_CNT_MAX)
         ecnt_next = ecnt_next + 8'd1;
      // fixed priority, own requests first; a grant stands while held
      gnt_next = gnt_reg;
      if ((gnt_reg & reqs) == '0)
         gnt_next = first_one(reqs);
      tmo_next = '0;
      if (sysen_reg[SYSEN_TMO] && (sbm_o.as || sb_dev_as_i) && !tmo_hit
          && !(sb_ack_i || sb_err_i || sb_rerun_i))
         tmo_next = tmo_reg + 16'd1;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctx_reg <= '0;
         sysen_reg <= SYSEN_RST;
         cause_reg <= '0;
         eaddr_reg <= '0;
         emast_reg <= '0;
         ecnt_reg <= '0;
         wack_reg <= 1'b0;
         dat_reg <= '0;
         gnt_reg <= '0;
         tmo_reg <= '0;
         sbrst_reg <= 1'b0;
      end
      else
      begin
         ctx_reg <= ctx_next;
         sysen_reg <= sysen_next;
         cause_reg <= cause_next;
         eaddr_reg <= eaddr_next;
         emast_reg <= emast_next;
         ecnt_reg <= ecnt_next;
         wack_reg <= wack_next;
         dat_reg <= dat_next;
         gnt_reg <= gnt_next;
         tmo_reg <= tmo_next;
         sbrst_reg <= hip_reset_i;
      end
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   fill_whole_a: assert property (tag_we_o && tag_wdata_o.valid |->
      $past(beat_reg) == 2'd3 && $past(kind_reg) == K_FILL)
      else $error("line marked valid before four words");
   tag_value_a: assert property (tag_we_o && tag_wdata_o.valid |->
      tag_wdata_o.tag == tag_of(addr_reg)) else $error("bad tag written");
   init_inval_a: assert property (st_reg == S_INIT && tag_we_o |->
      !tag_wdata_o.valid) else $error("sweep wrote a valid tag");
   hit_answer_a: assert property (st_reg == S_LOOK && !we_reg &&
      !byte_reg && hit |=> hip_ack_o && hip_rdata_o == $past(cd_rdata_i))
      else $error("hit not answered from cache");
   write_flush_a: assert property (st_reg == S_LOOK && we_reg && match
      |=> tag_we_o && !tag_wdata_o.valid) else $error("write hit not flushed");
   write_thru_a: assert property (st_reg == S_LOOK && we_reg |=>
      wbuf_valid_o) else $error("write not sent to buffer");
   wbuf_ack_a: assert property (wbuf_valid_o && wbuf_ready_i |=>
      hip_ack_o ##1 !wbuf_valid_o) else $error("buffered write not acked");
   bus_reset_a: assert property (hip_reset_i |-> ##1 sb_reset_o)
      else $error("bus reset not driven");
   xfer_grant_a: assert property (sbm_o.as |-> gnt_reg[0] &&
      $onehot0(gnt_reg)) else $error("transfer without grant");
   tmo_error_a: assert property (own_tmo |=> hip_err_o &&
      cause_reg[CAUSE_TMO] && ecnt_reg != 8'h0) else $error("timeout lost");
   byte_pack_a: assert property (st_reg == S_XFER && kind_reg == K_BYTE
      && sb_ack_i && beat_reg == 2'd3 |=> hip_ack_o &&
      hip_rdata_o[7:0] == $past(sb_data_i[7:0])) else $error("byte pack");
   ctx_copy_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
      wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTX |=>
      ctx_o == $past(wb_dat_i[CTXW-1:0])) else $error("context not copied");
endmodule

// *** src/wtc_pkg.sv ***
// wtc_pkg: constants and types of the write-through cache and bus controller
// assumes 32-bit words, 16-byte lines and an external 20-bit tag store
package wtc_pkg;
   localparam int unsigned LINE_BYTES = 16;
   localparam int unsigned LINE_WORDS = 4;
   localparam int unsigned OFFS_W = 4;
   localparam int unsigned TAG_W = 20;
   localparam int unsigned MIN_LINES = 4096;
   localparam int unsigned MAX_LINES = 16384;
   localparam int unsigned CTX_W = 4;
   localparam int unsigned DEV_MASTERS = 4;
   localparam int unsigned TMO_CYC = 255;

   localparam logic [7:0] REG_CTX = 8'h00;
   localparam logic [7:0] REG_SYSEN = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ERR_CAUSE = 8'h10;
   localparam logic [7:0] REG_ERR_ADDR = 8'h14;
   localparam logic [7:0] REG_ERR_MASTER = 8'h18;
   localparam logic [7:0] REG_ERR_COUNT = 8'h1c;

   localparam int unsigned SYSEN_CACHE = 0;
   localparam int unsigned SYSEN_ARB = 1;
   localparam int unsigned SYSEN_TMO = 2;
   localparam logic [2:0] SYSEN_RST = 3'h6;
   localparam int unsigned CAUSE_TMO = 0;
   localparam int unsigned CAUSE_ERR = 1;
   localparam int unsigned CAUSE_DEV = 2;
   localparam logic [7:0] ERR_CNT_MAX = 8'hff;

   typedef enum logic [2:0]
   {
      S_INIT, S_IDLE, S_LOOK, S_WPUSH, S_BREQ, S_XFER, S_RERUN
   } wtc_state_t;
   typedef enum logic [1:0] {K_FILL, K_SINGLE, K_BYTE} wtc_kind_t;
   typedef struct packed
   {
      logic valid;
      logic [TAG_W-2:0] tag;
   } wtc_tag_t;
   typedef struct packed
   {
      logic as;
      logic byte_sz;
      logic [31:0] addr;
   } wtc_sbm_t;
endpackage

// *** verif/wtc_sbus_dev.sv ***
// wtc_sbus_dev: behavioural bus slave answering the controller's transfers
// assumes one answer per beat; data pattern is known to the bench
`timescale 1ns/1ps
module wtc_sbus_dev
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire wtc_pkg::wtc_sbm_t sbm_i,
   input wire logic [1:0] mode_i,
   input wire logic slow_i,
   output logic [31:0] data_o,
   output logic ack_o,
   output logic err_o,
   output logic rerun_o,
   output logic [7:0] beats_o
);
   import wtc_pkg::*;
   logic [2:0] wait_reg;
   logic reran_reg;
   // mode 0 answers, 1 stays silent, 2 answers error, 3 reruns once
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {data_o, ack_o, err_o, rerun_o, beats_o} <= '0;
         wait_reg <= 3'h0;
         reran_reg <= 1'h0;
      end
      else
      begin
         ack_o <= 1'h0;
         err_o <= 1'h0;
         rerun_o <= 1'h0;
         // released lines must not keep showing the last word
         data_o <= ~data_o;
         if (mode_i != 2'h3)
            reran_reg <= 1'h0;
         if (sbm_i.as && !ack_o && !err_o && !rerun_o)
         begin
            if (wait_reg < (slow_i ? 3'h3 : 3'h0))
               wait_reg <= wait_reg + 3'h1;
            else
            begin
               wait_reg <= 3'h0;
               if (mode_i == 2'h2)
                  err_o <= 1'h1;
               else if (mode_i == 2'h3 && !reran_reg)
               begin
                  rerun_o <= 1'h1;
                  reran_reg <= 1'h1;
               end
               else if (mode_i != 2'h1)
               begin
                  ack_o <= 1'h1;
                  beats_o <= beats_o + 8'h1;
                  data_o <= sbm_i.byte_sz ? {4{sbm_i.addr[7:0] ^ 8'h5a}}
                     : sbm_i.addr ^ 32'h5a5a_0000;
               end
            end
         end
      end
   end
endmodule

// *** verif/wtc_ctrl_tb.sv ***
// wtc_ctrl_tb: self-checking bench for the cache and bus controller
// assumes wtc_sbus_dev as slave; tag, data stores and write buffer here
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      cmp_count++; \
      if ((got) !== (ex)) \
      begin \
         fails++; \
         $display("ERROR %s expected %h seen %h", nm, ex, got); \
      end \
   end
module wtc_ctrl_tb;
   import wtc_pkg::*;
   localparam int unsigned LINES = 16;
   localparam int unsigned TMOC = 8;
   int fails = 0, cmp_count = 0, cyc = 0, n, hlat;
   logic ref_clk_i = 1'h0, rst_i = 1'h1;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h0, beats, b0;
   logic [3:0] wb_sel_i = 4'hf, sb_br_i = 4'h0, sb_bg_o, ctx_o, tag_addr_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rq, hrd, ex, wq_addr, wq_data;
   logic hip_reset_i = 1'h0, hip_req_i = 1'h0, hip_we_i = 1'h0;
   logic hip_bytewide_i = 1'h0, hip_ack_o, hip_err_o, herr;
   logic [31:0] hip_addr_i = 32'h0, hip_wdata_i = 32'h0, hip_rdata_o;
   logic tag_we_o, cd_we_o, wbuf_valid_o, wbuf_ready_i = 1'h0, sb_reset_o;
   logic [5:0] cd_addr_o;
   logic [31:0] cd_wdata_o, cd_rdata_i, wbuf_addr_o, wbuf_data_o, sb_data_i;
   logic sb_dev_as_i = 1'h0, sb_ack_i, sb_err_i, sb_rerun_i, sb_tmo_o;
   logic [1:0] mode = 2'h0;
   logic slow = 1'h1;
   wtc_tag_t tag_wdata_o, tag_rdata_i;
   wtc_sbm_t sbm_o;
   wtc_tag_t tag_mem [LINES];
   logic [31:0] cd_mem [LINES*4];

   always #4 ref_clk_i = ~ref_clk_i;
   assign tag_rdata_i = tag_mem[tag_addr_o];
   assign cd_rdata_i = cd_mem[cd_addr_o];

   wtc_ctrl #(.CACHE_LINES(LINES), .TMO(TMOC)) u_dut (.ref_clk_i, .rst_i,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .hip_reset_i, .hip_req_i, .hip_we_i,
      .hip_bytewide_i, .hip_addr_i, .hip_wdata_i, .hip_rdata_o, .hip_ack_o,
      .hip_err_o, .tag_addr_o, .tag_we_o, .tag_wdata_o, .tag_rdata_i,
      .cd_addr_o, .cd_we_o, .cd_wdata_o, .cd_rdata_i, .wbuf_valid_o,
      .wbuf_ready_i, .wbuf_addr_o, .wbuf_data_o, .sb_reset_o, .sb_br_i,
      .sb_bg_o, .sb_dev_as_i, .sbm_o, .sb_data_i, .sb_ack_i, .sb_err_i,
      .sb_rerun_i, .sb_tmo_o, .ctx_o);
   wtc_sbus_dev u_dev (.clk_i(ref_clk_i), .rst_i, .sbm_i(sbm_o),
      .mode_i(mode), .slow_i(slow), .data_o(sb_data_i), .ack_o(sb_ack_i),
      .err_o(sb_err_i), .rerun_o(sb_rerun_i), .beats_o(beats));

   always @(posedge ref_clk_i)
   begin
      if (tag_we_o)
         tag_mem[tag_addr_o] <= tag_wdata_o;
      if (cd_we_o)
         cd_mem[cd_addr_o] <= cd_wdata_o;
      // buffer stalls one cycle before taking each word
      wbuf_ready_i <= wbuf_valid_o && !wbuf_ready_i;
      if (wbuf_valid_o && wbuf_ready_i)
      begin
         wq_addr <= wbuf_addr_o;
         wq_data <= wbuf_data_o;
      end
      cyc++;
      if (cyc == 10000)
      begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wb_rw(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge ref_clk_i);
         k++;
      end while (wb_ack_o !== 1'h1 && k < 50);
      if (wb_ack_o !== 1'h1)
         fails++;
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge ref_clk_i);
   endtask

   task automatic host(input logic we, input logic bw,
      input logic [31:0] a, input logic [31:0] d);
      hip_req_i <= 1'h1;
      hip_we_i <= we;
      hip_bytewide_i <= bw;
      hip_addr_i <= a;
      hip_wdata_i <= d;
      hlat = 0;
      do
      begin
         @(posedge ref_clk_i);
         hlat++;
      end while (hip_ack_o !== 1'h1 && hip_err_o !== 1'h1 && hlat < 400);
      if (hip_ack_o !== 1'h1 && hip_err_o !== 1'h1)
         fails++;
      herr = hip_err_o;
      hrd = hip_rdata_o;
      hip_req_i <= 1'h0;
      @(posedge ref_clk_i);
   endtask

   initial
   begin
      // stale valid entries: only the sweep can clear them
      for (int i = 0; i < LINES; i++)
         tag_mem[i] = '{valid: 1'h1, tag: '0};
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'h0;
      @(posedge ref_clk_i);
      wb_rw(1'h0, REG_SYSEN, 32'h0, rq);
      `CHK("sysen reset", SYSEN_RST, rq[2:0])
      wb_rw(1'h1, REG_CTX, 32'ha, rq);
      `CHK("ctx copy", 4'ha, ctx_o)
      wb_rw(1'h0, REG_CTX, 32'h0, rq);
      `CHK("ctx read", 4'ha, rq[3:0])
      wb_rw(1'h0, 8'h40, 32'h0, rq);
      `CHK("unmapped read", 32'h0, rq)
      n = 0;
      do
      begin
         wb_rw(1'h0, REG_STATUS, 32'h0, rq);
         n++;
      end while (rq[0] !== 1'h0 && n < 40);
      for (int i = 0; i < LINES; i++)
         `CHK("tag invalid", 1'h0, tag_mem[i].valid)
      wb_rw(1'h1, REG_SYSEN, 32'h7, rq);
      b0 = beats;
      host(1'h0, 1'h0, 32'h1238, 32'h0);
      `CHK("miss data", 32'h5a5a_1238, hrd)
      `CHK("fill beats", b0 + 8'h4, beats)
      slow <= 1'h0;
      for (int i = 0; i < 4; i++)
      begin
         host(1'h0, 1'h0, 32'h1230 + 4 * i, 32'h0);
         `CHK("hit data", 32'h5a5a_1230 + 4 * i, hrd)
         `CHK("hit latency", 3, hlat)
      end
      `CHK("hits no bus", b0 + 8'h4, beats)
      host(1'h1, 1'h0, 32'h1238, 32'hdead_beef);
      `CHK("wbuf addr", 32'h1238, wq_addr)
      `CHK("wbuf data", 32'hdead_beef, wq_data)
      host(1'h1, 1'h0, 32'h2000, 32'h1);
      `CHK("wbuf miss addr", 32'h2000, wq_addr)
      `CHK("writes off bus", b0 + 8'h4, beats)
      host(1'h0, 1'h0, 32'h1238, 32'h0);
      `CHK("flushed refill", b0 + 8'h8, beats)
      b0 = beats;
      host(1'h0, 1'h1, 32'h0101, 32'h0);
      ex = 32'h0;
      for (int i = 1; i < 5; i++)
         ex = {ex[23:0], 8'(i) ^ 8'h5a};
      `CHK("byte word", ex, hrd)
      `CHK("byte beats", b0 + 8'h4, beats)
      mode <= 2'h2;
      host(1'h0, 1'h0, 32'h3000, 32'h0);
      `CHK("error ack", 1'h1, herr)
      wb_rw(1'h0, REG_ERR_CAUSE, 32'h0, rq);
      `CHK("cause err", 3'h2, rq[2:0])
      wb_rw(1'h0, REG_ERR_ADDR, 32'h0, rq);
      `CHK("err addr", 32'h3000, rq)
      wb_rw(1'h0, REG_ERR_COUNT, 32'h0, rq);
      `CHK("err count", 8'h1, rq[7:0])
      wb_rw(1'h1, REG_ERR_CAUSE, 32'h7, rq);
      mode <= 2'h1;
      host(1'h0, 1'h0, 32'h4000, 32'h0);
      `CHK("timeout err", 1'h1, herr)
      `CHK("timeout late", 1'h1, hlat > TMOC)
      wb_rw(1'h0, REG_ERR_CAUSE, 32'h0, rq);
      `CHK("cause tmo", 3'h1, rq[2:0])
      wb_rw(1'h1, REG_ERR_CAUSE, 32'h7, rq);
      mode <= 2'h3;
      b0 = beats;
      host(1'h0, 1'h0, 32'h5000, 32'h0);
      `CHK("rerun data", 32'h5a5a_5000, hrd)
      `CHK("rerun beats", b0 + 8'h4, beats)
      mode <= 2'h0;
      wb_rw(1'h1, REG_SYSEN, 32'h6, rq);
      b0 = beats;
      host(1'h0, 1'h0, 32'h1238, 32'h0);
      `CHK("uncached beat", b0 + 8'h1, beats)
      sb_br_i <= 4'h2;
      n = 0;
      do
      begin
         @(negedge ref_clk_i);
         n++;
      end while (sb_bg_o !== 4'h2 && n < 10);
      `CHK("grant dev1", 4'h2, sb_bg_o)
      @(posedge ref_clk_i);
      sb_dev_as_i <= 1'h1;
      n = 0;
      do
      begin
         @(negedge ref_clk_i);
         n++;
      end while (sb_tmo_o !== 1'h1 && n < 300);
      `CHK("dev timeout", 1'h1, sb_tmo_o)
      `CHK("dev tmo late", 1'h1, n >= TMOC)
      @(posedge ref_clk_i);
      sb_dev_as_i <= 1'h0;
      sb_br_i <= 4'h0;
      @(posedge ref_clk_i);
      wb_rw(1'h0, REG_ERR_CAUSE, 32'h0, rq);
      `CHK("cause dev", 3'h4, rq[2:0])
      wb_rw(1'h0, REG_ERR_MASTER, 32'h0, rq);
      `CHK("err master", 32'h4, rq)
      wb_rw(1'h1, REG_SYSEN, 32'h5, rq);
      sb_br_i <= 4'h1;
      repeat (4) @(posedge ref_clk_i);
      `CHK("arb off", 4'h0, sb_bg_o)
      sb_br_i <= 4'h0;
      hip_reset_i <= 1'h1;
      repeat (2) @(negedge ref_clk_i);
      `CHK("bus reset on", 1'h1, sb_reset_o)
      @(posedge ref_clk_i);
      hip_reset_i <= 1'h0;
      repeat (2) @(negedge ref_clk_i);
      `CHK("bus reset off", 1'h0, sb_reset_o)
      give_verdict();
   end
endmodule
